// *** hw/bit_fifo.sv ***
// Purpose: small synchronous FIFO between shift sampling and shift register
// Assumes: single clock, push ignored when full, pop ignored when empty
// Notes:   full and empty come from a registered count
`timescale 1ns/1ps
`default_nettype none

module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             in_ready,
  // draining side
  output var  logic             out_valid,
  output var  logic [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  // handshakes on both sides
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // pointer and count next values
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // pointer and count registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage, written only on push
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule : bit_fifo

`default_nettype wire

// *** hw/sipo_latch_driver.sv ***
// Purpose: 8-bit serial-in, parallel-out driver with level latch and clear
// Assumes: host pins are asynchronous to clk and pass two flip-flops first
// Notes:   a FIFO carries sampled bits from the pin edge to the shift stages
`include "sipo_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module sipo_latch_driver
  import sipo_pkg::*;
#(
  parameter int STAGES     = `SIPO_STAGES,
  parameter int FIFO_DEPTH = `SIPO_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // host pins
  input  wire logic              shift_clk,
  input  wire logic              serial_data,
  input  wire logic              latch_strobe_n,
  input  wire logic              latch_clear_n,
  // local drain control
  input  wire logic              drain_hold,
  // outputs
  output var  logic [STAGES-1:0] parallel_out,
  output var  logic              serial_out,
  output var  logic              shift_in_ready
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  pin_sample_t       pins_raw;
  pin_sample_t       sync_a;
  pin_sample_t       sync_b;
  logic              clk_seen;
  logic              shift_rise;
  logic              clear_s;
  logic              strobe_s;

  assign pins_raw = '{shift_clk:      shift_clk,
                      serial_data:    serial_data,
                      latch_strobe_n: latch_strobe_n,
                      latch_clear_n:  latch_clear_n};

  // two-flop synchroniser plus edge history
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_a   <= `SIPO_PINS_IDLE;
      sync_b   <= `SIPO_PINS_IDLE;
      clk_seen <= 1'b1;
    end else begin
      sync_a   <= pins_raw;
      sync_b   <= sync_a;
      clk_seen <= sync_b.shift_clk;
    end
  end

  assign shift_rise = sync_b.shift_clk && !clk_seen;
  assign clear_s    = sync_b.latch_clear_n;
  assign strobe_s   = sync_b.latch_strobe_n;

  // ****************************************
  // bit FIFO
  // ****************************************
  logic              fifo_in_ready;
  logic              fifo_valid;
  logic              fifo_bit;
  logic              pop;

  bit_fifo #(
    .WIDTH (1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (shift_rise),
    .in_data   (sync_b.serial_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_bit),
    .out_ready (!drain_hold)
  );

  assign pop = fifo_valid && !drain_hold;

  // ready to the filling side, registered
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_in_ready <= 1'b1;
    end else begin
      shift_in_ready <= fifo_in_ready;
    end
  end

  // ****************************************
  // shift register and latch
  // ****************************************
  // eight shift stages
  logic [STAGES-1:0] shift_reg;
  logic [STAGES-1:0] next_shift_reg;
  logic [STAGES-1:0] next_parallel_out;

  // next values of stages and latch
  always_comb begin
    next_shift_reg    = shift_reg;
    next_parallel_out = parallel_out;
    if (pop) begin
      next_shift_reg = {shift_reg[STAGES-2:0], fifo_bit};
    end
    if (!clear_s) begin
      next_parallel_out = `SIPO_LATCH_RESET;
    end else if (!strobe_s && !fifo_valid) begin
      next_parallel_out = shift_reg;
    end
  end

  // stage and latch registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_reg    <= `SIPO_SHIFT_RESET;
      parallel_out <= `SIPO_LATCH_RESET;
    end else begin
      shift_reg    <= next_shift_reg;
      parallel_out <= next_parallel_out;
    end
  end

  // last stage always on serial output
  assign serial_out = shift_reg[STAGES-1];

  // ****************************************
  // assertions
  // ****************************************
  property p_shift_in;
    @(posedge clk) disable iff (!reset_n)
      pop |=> shift_reg == {$past(shift_reg[STAGES-2:0]), $past(fifo_bit)};
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("shift stages did not advance on pop");

  property p_edge_queued;
    @(posedge clk) disable iff (!reset_n)
      (shift_rise && fifo_in_ready && drain_hold) |=> fifo_valid;
  endproperty
  a_edge_queued: assert property (p_edge_queued)
    else $error("shift clock rise was not queued");

  property p_copy;
    @(posedge clk) disable iff (!reset_n)
      (clear_s && !strobe_s && !fifo_valid) |=> parallel_out == $past(shift_reg);
  endproperty
  a_copy: assert property (p_copy)
    else $error("latch did not copy stages under strobe");

  property p_hold;
    @(posedge clk) disable iff (!reset_n)
      (clear_s && strobe_s) |=> $stable(parallel_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("latch changed while strobe high");

  property p_transparent;
    @(posedge clk) disable iff (!reset_n)
      (clear_s && !strobe_s && !fifo_valid && pop == 1'b0) [*2]
        |=> parallel_out == shift_reg;
  endproperty
  a_transparent: assert property (p_transparent)
    else $error("latch not transparent during strobe");

  property p_clear_pin;
    @(posedge clk) disable iff (!reset_n)
      (!latch_clear_n) [*3] |=> parallel_out == '0;
  endproperty
  a_clear_pin: assert property (p_clear_pin)
    else $error("clear pin did not reset latch in time");

  property p_clear_low;
    @(posedge clk) disable iff (!reset_n)
      !clear_s |=> parallel_out == '0;
  endproperty
  a_clear_low: assert property (p_clear_low)
    else $error("outputs not low under clear");

  property p_serial;
    @(posedge clk) disable iff (!reset_n)
      pop |=> serial_out == $past(shift_reg[STAGES-2]);
  endproperty
  a_serial: assert property (p_serial)
    else $error("serial output not the last stage");

  property p_order;
    @(posedge clk) disable iff (!reset_n)
      (pop && drain_hold == 1'b0) |=> shift_reg[0] == $past(fifo_bit);
  endproperty
  a_order: assert property (p_order)
    else $error("newest bit not at lowest stage");

  property p_ready_reg;
    @(posedge clk) disable iff (!reset_n)
      1'b1 |=> shift_in_ready == $past(fifo_in_ready);
  endproperty
  a_ready_reg: assert property (p_ready_reg)
    else $error("ready flag out of step with FIFO");

endmodule : sipo_latch_driver

`default_nettype wire

// *** hw/sipo_pkg.sv ***
// Purpose: types shared by the latch driver and its testbench
// Assumes: sipo_regs.svh for sizes
// Notes:   pin samples travel as one packed struct
`include "sipo_regs.svh"

package sipo_pkg;

  // ****************************************
  // carrier types
  // ****************************************
  // one sample of the four host pins
  typedef struct packed {
    logic shift_clk;
    logic serial_data;
    logic latch_strobe_n;
    logic latch_clear_n;
  } pin_sample_t;

  typedef logic [`SIPO_STAGES-1:0] stage_word_t;

endpackage : sipo_pkg

// *** hw/sipo_regs.svh ***
// Purpose: shared constants of the serial-in, parallel-out latch driver
// Assumes: included by its bare name from the package and design files
// Notes:   definitions only
`ifndef SIPO_REGS_SVH
`define SIPO_REGS_SVH

// ****************************************
// sizes
// ****************************************
`define SIPO_STAGES      8
`define SIPO_FIFO_DEPTH  16
`define SIPO_SYNC_DEPTH  2

// ****************************************
// reset values
// ****************************************
`define SIPO_SHIFT_RESET 8'h00
`define SIPO_LATCH_RESET 8'h00
`define SIPO_PINS_IDLE   4'hF

`endif

// *** tb/sipo_host_model.sv ***
// Purpose: host model driving the serial pins
// Assumes: clk is the bench clock
// Notes:   data shows inverse once its hold is over
`timescale 1ns/1ps
`default_nettype none

module sipo_host_model (
  // bench clock
  input  wire logic clk,
  // serial pins
  output var  logic shift_clk,
  output var  logic serial_data
);
  initial begin
    shift_clk   = 1'b0;
    serial_data = 1'b0;
  end

  task automatic send_byte(input logic [7:0] b, input int slow);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk) serial_data <= b[i];
      repeat (3 + slow) @(posedge clk);
      shift_clk <= 1'b1;
      repeat (4 + slow) @(posedge clk);
      shift_clk   <= 1'b0;
      serial_data <= ~b[i];
    end
  endtask : send_byte
endmodule : sipo_host_model
`default_nettype wire

// *** tb/sipo_latch_driver_tb_top.sv ***
// Purpose: self-checking bench of the latch driver
// Assumes: host model drives the serial pins
// Notes:   bytes from a fixed-seed xorshift
`timescale 1ns/1ps
`default_nettype none

module sipo_latch_driver_tb_top;
  import sipo_pkg::*;
  logic        clk;
  logic        reset_n;
  logic        latch_strobe_n;
  logic        latch_clear_n;
  logic        drain_hold;
  logic        shift_clk;
  logic        serial_data;
  stage_word_t parallel_out;
  logic        serial_out;
  logic        shift_in_ready;
  int          n_mismatch;
  int          compares;
  logic [31:0] seed;
  stage_word_t a;
  stage_word_t b;
  stage_word_t kept;

  // bench clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  sipo_host_model host (.clk(clk), .shift_clk(shift_clk), .serial_data(serial_data));

  sipo_latch_driver DUT (
    .clk(clk), .reset_n(reset_n), .shift_clk(shift_clk), .serial_data(serial_data),
    .latch_strobe_n(latch_strobe_n), .latch_clear_n(latch_clear_n),
    .drain_hold(drain_hold), .parallel_out(parallel_out), .serial_out(serial_out),
    .shift_in_ready(shift_in_ready)
  );

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // bounded wait for the outputs to settle
  task automatic wait_po(input string name, input stage_word_t exp);
    int n;
    n = 0;
    while (parallel_out !== exp && n < 40) begin
      @(negedge clk);
      n++;
    end
    check(name, parallel_out, exp);
  endtask : wait_po

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // watchdog
  initial begin
    repeat (50000) @(posedge clk);
    n_mismatch++;
    test_done();
  end

  initial begin
    reset_n        = 1'b0;
    latch_strobe_n = 1'b1;
    latch_clear_n  = 1'b1;
    drain_hold     = 1'b0;
    n_mismatch     = 0;
    compares       = 0;
    seed           = 32'h0000_6245;
    a              = 8'h00;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    check("po_reset", parallel_out, 8'h00);
    check("ready_reset", 8'(shift_in_ready), 8'h01);
    // corner then random bytes, fast and slow host
    for (int i = 0; i < 8; i++) begin
      seed = xorshift(seed);
      b = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : seed[7:0];
      host.send_byte(b, (i % 2) * 3);
      repeat (8) @(negedge clk);
      check("po_hold", parallel_out, a);
      check("serial_out", 8'(serial_out), 8'(b[7]));
      @(posedge clk) latch_strobe_n <= 1'b0;
      wait_po("po_strobe", b);
      @(posedge clk) latch_strobe_n <= 1'b1;
      a = b;
    end
    // transparent while strobe low
    @(posedge clk) latch_strobe_n <= 1'b0;
    seed = xorshift(seed);
    b = seed[7:0] | 8'h01;
    host.send_byte(b, 0);
    wait_po("po_transp", b);
    // clear with strobe high, then release
    @(posedge clk) latch_strobe_n <= 1'b1;
    @(posedge clk) latch_clear_n <= 1'b0;
    wait_po("po_clear", 8'h00);
    @(posedge clk) latch_clear_n <= 1'b1;
    repeat (8) @(negedge clk);
    check("po_after_clear", parallel_out, 8'h00);
    @(posedge clk) latch_strobe_n <= 1'b0;
    wait_po("po_kept", b);
    // fill the FIFO while drain stalls
    @(posedge clk) drain_hold <= 1'b1;
    kept = b;
    seed = xorshift(seed);
    a = seed[7:0];
    b = seed[15:8];
    host.send_byte(a, 0);
    host.send_byte(b, 0);
    repeat (4) @(negedge clk);
    check("ready_full", 8'(shift_in_ready), 8'h00);
    check("po_wait", parallel_out, kept);
    host.send_byte(~b, 0);
    @(posedge clk) drain_hold <= 1'b0;
    wait_po("po_drain", b);
    check("ready_empty", 8'(shift_in_ready), 8'h01);
    test_done();
  end
endmodule : sipo_latch_driver_tb_top
`default_nettype wire
